/* File: inc/ptf_pkg.sv */
// Constants and types shared by the position telemetry framer
package ptf_pkg;

    // ********
    // Timing
    // ********
    localparam int unsigned CLK_FREQ_HZ      = 125_000_000;
    localparam int unsigned BAUD_RATE        = 300;
    localparam int unsigned SECOND_S         = 1;
    localparam int unsigned BIT_CYCLES       = CLK_FREQ_HZ / BAUD_RATE;
    localparam int unsigned SECOND_CYCLES    = CLK_FREQ_HZ * SECOND_S;
    localparam int unsigned INHERENT_DELAY_S = 2;
    localparam int unsigned MIN_INTERVAL_S   = 2;
    localparam int unsigned MAX_INTERVAL_S   = 3599;

    // ********
    // Message layout
    // ********
    localparam int unsigned MSG_CHARS   = 24;
    localparam int unsigned CHAR_BITS   = 10;
    localparam int unsigned CHAR_W      = 8;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam int unsigned TD_DIGITS   = 6;
    localparam int unsigned TD_W        = 4 * TD_DIGITS;
    localparam logic [4:0] POS_STATUS   = 5'h04;
    localparam logic [4:0] POS_REPORT   = 5'h05;
    localparam logic [4:0] POS_SPACE_A  = 5'h07;
    localparam logic [4:0] POS_FIRST    = 5'h08;
    localparam logic [4:0] POS_SPACE_B  = 5'h0f;
    localparam logic [4:0] POS_SECOND   = 5'h10;
    localparam logic [4:0] POS_END      = 5'h17;
    localparam logic [4:0] TD_LAST_OFS  = 5'h06;
    localparam logic [7:0] ASCII_ZERO   = 8'h30;
    localparam logic [7:0] ASCII_SPACE  = 8'h20;
    localparam logic [7:0] ASCII_CR     = 8'h0d;

    // ********
    // Register port
    // ********
    localparam int unsigned ADDR_W   = 5;
    localparam int unsigned DATA_W   = 16;
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_INTERVAL = 5'h04;
    localparam logic [4:0] OFS_VESSEL   = 5'h08;
    localparam logic [4:0] OFS_CODE     = 5'h0c;
    localparam logic [4:0] OFS_STATUS   = 5'h10;
    localparam int unsigned CTRL_ENABLE  = 0;
    localparam int unsigned CTRL_AUTO    = 1;
    localparam int unsigned CTRL_MICTIED = 2;
    localparam int unsigned CODE_REPORT  = 4;
    localparam int unsigned STAT_BUSY    = 0;
    localparam int unsigned STAT_KEY     = 1;
    localparam int unsigned STAT_PENDING = 2;
    localparam int unsigned STAT_VOICE   = 3;
    localparam int unsigned STAT_COUNT   = 8;
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] INTERVAL_RST = 16'h003c;
    localparam logic [15:0] VESSEL_RST   = 16'h0000;
    localparam logic [15:0] CODE_RST     = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } ptf_state_t;

endpackage

/* File: verification/ptf_framer_properties.sv */
// Port-level assertions for the telemetry framer
`timescale 1ns/10ps
module ptf_framer_checker #(
    parameter int unsigned P_BIT_CYCLES = 4
) (
    input  logic        i_core_clk,
    input  logic        i_reset_n,
    input  logic        i_rd,
    input  logic [15:0] o_rdata,
    input  logic        i_mic_key,
    input  logic        o_tx_serial,
    input  logic        o_tx_key
);
    import ptf_pkg::*;
    localparam int MSG_LEN = MSG_CHARS * CHAR_BITS * P_BIT_CYCLES;
    int   run_len;
    int   key_len;
    logic prev_line;
    logic mic_seen;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    // ********
    // Run lengths of line and key
    // ********
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run_len   <= 0;
            key_len   <= 0;
            prev_line <= 1'b1;
            mic_seen  <= 1'b0;
        end else begin
            prev_line <= o_tx_serial;
            run_len   <= (o_tx_serial != prev_line) ? 1 : run_len + 1;
            key_len   <= o_tx_key ? key_len + 1 : 0;
            // An aborted message is short on purpose, so length checks skip it
            mic_seen  <= o_tx_key & (mic_seen | i_mic_key);
        end
    end

    property p_idle_high;
        !o_tx_key |-> o_tx_serial;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("line not idle high while unkeyed");
    property p_voice_drop;
        i_mic_key [*6] |-> !o_tx_key;
    endproperty
    a_voice_drop: assert property (p_voice_drop)
        else $error("key held during voice");
    property p_voice_start;
        $rose(o_tx_key) |-> !$past(i_mic_key, 2);
    endproperty
    a_voice_start: assert property (p_voice_start)
        else $error("key raised during voice");
    property p_start_bit;
        $rose(o_tx_key) && !i_mic_key |-> ##[1:6] !o_tx_serial;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("no start bit after key");
    property p_bit_time;
        $rose(o_tx_serial) && o_tx_key && $past(o_tx_key) |-> (run_len % P_BIT_CYCLES) == 0;
    endproperty
    a_bit_time: assert property (p_bit_time)
        else $error("low run not whole bits");
    property p_msg_len;
        $fell(o_tx_key) && !mic_seen |-> key_len >= MSG_LEN && key_len <= MSG_LEN + 60;
    endproperty
    a_msg_len: assert property (p_msg_len)
        else $error("key length off");
    property p_stop_tail;
        $fell(o_tx_key) && !mic_seen |-> o_tx_serial && run_len >= P_BIT_CYCLES;
    endproperty
    a_stop_tail: assert property (p_stop_tail)
        else $error("key dropped before stop bit ended");
    property p_rdata_quiet;
        !$past(i_rd) |-> o_rdata == '0;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet)
        else $error("read data outside read slot");
endmodule

bind ptf_framer ptf_framer_checker #(
    .P_BIT_CYCLES(P_BIT_CYCLES)
) ptf_framer_checker_inst (
    .i_core_clk,
    .i_reset_n,
    .i_rd,
    .o_rdata,
    .i_mic_key,
    .o_tx_serial,
    .o_tx_key
);

/* File: verification/ptf_framer_test.sv */
// Self-checking bench for the position telemetry framer
`timescale 1ns/10ps
module ptf_framer_test;
    import ptf_pkg::*;
    localparam int unsigned BITC = 4;
    localparam int unsigned SECC = 50;
    logic        i_core_clk;
    logic        i_reset_n;
    logic [4:0]  i_addr;
    logic [15:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [15:0] o_rdata;
    logic [23:0] first_td;
    logic [23:0] second_td;
    logic        td_inhibit;
    logic        i_mic_key;
    logic        i_transmit_switch;
    logic        o_tx_serial;
    logic        o_tx_key;
    logic [15:0] vessel;
    logic [15:0] code;
    logic [23:0] exp_a;
    logic [23:0] exp_b;
    logic [15:0] rv;
    int          n;
    int          period;
    int          fail_count;
    int          checks_done;

    ptf_framer #(.P_BIT_CYCLES(BITC), .P_SECOND_CYCLES(SECC)) ptf_framer_inst (
        .i_core_clk,
        .i_reset_n,
        .i_addr,
        .i_wdata,
        .i_wr,
        .i_rd,
        .o_rdata,
        .i_first_time_difference (first_td),
        .i_second_time_difference (second_td),
        .i_td_inhibit (td_inhibit),
        .i_mic_key,
        .i_transmit_switch,
        .o_tx_serial,
        .o_tx_key
    );
    ptf_nav_model #(.P_BIT_CYCLES(BITC)) ptf_nav_model_inst (
        .i_core_clk,
        .i_tx_serial (o_tx_serial),
        .i_tx_key (o_tx_key),
        .o_first_time_difference (first_td),
        .o_second_time_difference (second_td),
        .o_td_inhibit (td_inhibit)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    // ********
    // Access and checking tasks
    // ********
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task report_and_stop();
        $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task wait_key(input logic v, input int limit);
        n = 0;
        while (o_tx_key !== v) begin
            @(posedge i_core_clk);
            #1 n++;
            if (n > limit) begin
                fail_count++;
                $display("unexpected at %0t: key wait ran out", $time);
                report_and_stop();
            end
        end
    endtask
    task pulse_switch();
        @(posedge i_core_clk);
        i_transmit_switch <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_transmit_switch <= 1'b0;
    endtask
    function logic [7:0] exp_char(input int i);
        logic [23:0] td;
        td = (i < 16) ? exp_a : exp_b;
        if (i < 4) return ASCII_ZERO + 8'(vessel[15 - 4 * i -: 4]);
        if (i == 4) return ASCII_ZERO + 8'(code[3:0]);
        if (i < 7) return ASCII_ZERO + 8'(code[11 - 4 * (i - 5) -: 4]);
        if (i == 7 || i == 15) return ASCII_SPACE;
        if (i == 14 || i == 22) return ASCII_ZERO;
        if (i == 23) return ASCII_CR;
        return ASCII_ZERO + 8'(td[23 - 4 * ((i - 8) % 8) -: 4]);
    endfunction
    task check_msg(input string name);
        wait_key(1'b1, 300);
        wait_key(1'b0, 1200);
        check(16'(ptf_nav_model_inst.rx_count), 16'd24);
        check(16'(ptf_nav_model_inst.frame_errs), 16'd0);
        for (int i = 0; i < 24; i++) begin
            check(16'(ptf_nav_model_inst.rx_chars[i]), 16'(exp_char(i)));
        end
        $display("test %s done", name);
    endtask

    initial begin
        {i_reset_n, i_wr, i_rd, i_mic_key, i_transmit_switch} = '0;
        i_addr      = '0;
        i_wdata     = '0;
        fail_count  = 0;
        checks_done = 0;
        vessel      = 16'h1234;
        code        = 16'h0567;
        exp_a       = 24'h123456;
        exp_b       = 24'h987650;
        repeat (6) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        rd(OFS_CTRL, rv);
        check(rv, CTRL_RST);
        rd(OFS_INTERVAL, rv);
        check(rv, INTERVAL_RST);
        rd(OFS_VESSEL, rv);
        check(rv, VESSEL_RST);
        wr(5'h14, 16'hffff);
        rd(5'h14, rv);
        check(rv, 16'h0000);
        wr(OFS_VESSEL, vessel);
        wr(OFS_CODE, code);
        rd(OFS_CODE, rv);
        check(rv, code);
        wr(OFS_INTERVAL, 16'h001e);
        wr(OFS_CTRL, 16'h0001);
        ptf_nav_model_inst.show(exp_a, exp_b, 1'b0);
        pulse_switch();
        check_msg("manual");
        // Digits behind a held inhibit must not reach the message
        ptf_nav_model_inst.show(24'h555555, 24'h666666, 1'b1);
        pulse_switch();
        check_msg("inhibit");
        exp_a = 24'h888888;
        exp_b = 24'h000009;
        ptf_nav_model_inst.show(exp_a, exp_b, 1'b0);
        pulse_switch();
        wait_key(1'b1, 300);
        repeat (60) @(posedge i_core_clk);
        i_mic_key <= 1'b1;
        repeat (40) @(posedge i_core_clk);
        #1 check(16'(o_tx_key), 16'h0000);
        i_mic_key <= 1'b0;
        check_msg("voice abort");
        wr(OFS_CTRL, 16'h0005);
        i_mic_key <= 1'b1;
        repeat (20) @(posedge i_core_clk);
        i_mic_key <= 1'b0;
        check_msg("after voice");
        wr(OFS_STATUS, 16'hffff);
        rd(OFS_STATUS, rv);
        check(rv, 16'h0400);
        wr(OFS_CTRL, 16'h0003);
        wait_key(1'b1, 3000);
        wait_key(1'b0, 1200);
        period = n;
        wait_key(1'b1, 2000);
        period = period + n;
        // One more cycle: a timer request is taken the cycle after it is raised
        check(16'(period), 16'((30 + INHERENT_DELAY_S) * SECC + 1));
        $display("test auto interval done");
        report_and_stop();
    end
endmodule

/* File: verification/ptf_nav_model.sv */
// Receiver digit source and serial-link listener facing the framer
`timescale 1ns/10ps
module ptf_nav_model #(
    parameter int unsigned P_BIT_CYCLES = 4
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_tx_serial,
    input  wire logic        i_tx_key,
    output logic [23:0]      o_first_time_difference,
    output logic [23:0]      o_second_time_difference,
    output logic             o_td_inhibit
);
    logic [7:0] rx_chars [0:23];
    int         rx_count;
    int         frame_errs;

    initial begin
        o_first_time_difference  = '0;
        o_second_time_difference = '0;
        o_td_inhibit             = 1'b0;
        rx_count                 = 0;
        frame_errs               = 0;
    end

    task show(input logic [23:0] a, input logic [23:0] b, input logic hold);
        @(posedge i_core_clk);
        o_td_inhibit <= 1'b1;
        @(posedge i_core_clk);
        o_first_time_difference  <= a;
        o_second_time_difference <= b;
        repeat (3) @(posedge i_core_clk);
        o_td_inhibit <= hold;
    endtask

    always @(posedge i_tx_key) rx_count = 0;

    // Samples mid-bit; a missing stop bit is counted, not hidden
    initial begin : listen
        logic [7:0] c;
        forever begin
            @(negedge i_tx_serial);
            if (i_tx_key) begin
                repeat (P_BIT_CYCLES / 2) @(posedge i_core_clk);
                for (int b = 0; b < 9; b++) begin
                    repeat (P_BIT_CYCLES) @(posedge i_core_clk);
                    if (b < 8) c[b] = i_tx_serial;
                end
                if (i_tx_serial !== 1'b1) frame_errs++;
                if (rx_count < 24) rx_chars[rx_count] = c;
                rx_count++;
            end
        end
    end
endmodule

/* File: verilog/ptf_fifo.sv */
// Character FIFO between message builder and serial shifter
`timescale 1ns/10ps
module ptf_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_flush,
    input  wire logic             i_wr_valid,
    input  wire logic [WIDTH-1:0] i_wr_data,
    output logic                  o_wr_ready,
    output logic                  o_rd_valid,
    output logic [WIDTH-1:0]      o_rd_data,
    input  wire logic             i_rd_ready
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
        logic                        valid;
        logic [WIDTH-1:0]            data;
    } ptf_fifo_t;

    ptf_fifo_t q;
    ptf_fifo_t next_q;
    logic      push;
    logic      pop;

    assign o_wr_ready = (q.count != CW'(DEPTH));
    assign o_rd_valid = q.valid;
    assign o_rd_data  = q.data;
    assign push       = i_wr_valid && o_wr_ready;
    assign pop        = q.valid && i_rd_ready;

    always_comb begin
        next_q = q;
        if (i_flush) begin
            next_q.wr_ptr = '0;
            next_q.rd_ptr = '0;
            next_q.count  = '0;
        end else begin
            if (push) begin
                next_q.mem[q.wr_ptr] = i_wr_data;
                next_q.wr_ptr        = (q.wr_ptr == PW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
            end
            if (pop) begin
                next_q.rd_ptr = (q.rd_ptr == PW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
            end
            next_q.count = q.count + CW'(push) - CW'(pop);
        end
        // Head is registered; the memory copy already holds a same-cycle write
        next_q.valid = (next_q.count != '0);
        next_q.data  = next_q.mem[next_q.rd_ptr];
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule

/* File: verilog/ptf_framer.sv */
// Telemetry framer: latches receiver digits, builds and keys out the message
`timescale 1ns/10ps

// Function
// - Message carries id, status, code, positions
// - Every message is exactly 24 characters; a voice abort cuts the message short
// - Characters shift out at 300 baud
// - Lowest digit of each block forced zero
// - Displayed data copied unfiltered into blocks
// - Short format without trailing time characters
// - Parallel BCD with inhibit becomes serial ASCII
// - Voice blocks data, data resumes afterwards
// - Send after voice, timer restarts then
// - Mic-tied or independent timing mode
// - Key by timer or transmit switch
// - Operator-selected intervals, auto or manual
// - One start, one stop bit per character
// - Interval two seconds to 59:59
// - Period is interval plus two seconds
// - Id, code, status taken as BCD
module ptf_framer #(
    parameter int unsigned P_BIT_CYCLES    = ptf_pkg::BIT_CYCLES,
    parameter int unsigned P_SECOND_CYCLES = ptf_pkg::SECOND_CYCLES
) (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_reset_n,
    input  wire logic [ptf_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [ptf_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic [ptf_pkg::DATA_W-1:0]     o_rdata,
    input  wire logic [ptf_pkg::TD_W-1:0]   i_first_time_difference,
    input  wire logic [ptf_pkg::TD_W-1:0]   i_second_time_difference,
    input  wire logic                      i_td_inhibit,
    input  wire logic                      i_mic_key,
    input  wire logic                      i_transmit_switch,
    output logic                           o_tx_serial,
    output logic                           o_tx_key
);
    import ptf_pkg::*;

    typedef struct packed {
        ptf_state_t  state;
        logic [15:0] ctrl;
        logic [15:0] interval;
        logic [15:0] vessel;
        logic [15:0] code;
        logic [15:0] rdata;
        logic        inh_meta;
        logic        inh;
        logic        mic_meta;
        logic        mic;
        logic        mic_prev;
        logic        sw_meta;
        logic        sw;
        logic        sw_prev;
        logic [23:0] first_meta;
        logic [23:0] first_sync;
        logic [23:0] second_meta;
        logic [23:0] second_sync;
        logic [23:0] first_live;
        logic [23:0] second_live;
        logic [23:0] first_snap;
        logic [23:0] second_snap;
        logic        pending;
        logic [4:0]  char_idx;
        logic [18:0] bit_div;
        logic [3:0]  bit_cnt;
        logic [9:0]  shift;
        logic        shifting;
        logic        tx;
        logic        key;
        logic [26:0] sec_div;
        logic [11:0] sec_cnt;
        logic [7:0]  msg_count;
    } ptf_framer_t;

    localparam logic [18:0] BIT_LAST  = 19'(P_BIT_CYCLES - 1);
    localparam logic [26:0] SEC_LAST  = 27'(P_SECOND_CYCLES - 1);
    localparam logic [11:0] MIN_INT   = 12'(MIN_INTERVAL_S);
    localparam logic [11:0] MAX_INT   = 12'(MAX_INTERVAL_S);
    localparam logic [11:0] DELAY_ADD = 12'(INHERENT_DELAY_S);
    localparam logic [3:0]  BIT_END   = 4'(CHAR_BITS - 1);
    localparam logic [4:0]  MSG_END   = 5'(MSG_CHARS);

    ptf_framer_t q;
    ptf_framer_t next_q;
    logic        fifo_push;
    logic [7:0]  fifo_wdata;
    logic        fifo_ready;
    logic        fifo_valid;
    logic [7:0]  fifo_rdata;
    logic        fifo_pop;
    logic        fifo_flush;

    // ********
    // Character selection
    // ********
    // message fields
    // short layout, ends in carriage return
    function automatic logic [7:0] ptf_char(input logic [4:0]  idx,
        input logic [15:0] vessel,
        input logic [15:0] code,
        input logic [23:0] first,
        input logic [23:0] second);
        logic [4:0] ofs;
        logic [7:0] ch;
        ofs = 5'h00;
        ch  = ASCII_SPACE;
        if (idx < POS_STATUS) begin
            ch = {4'h3, 4'(vessel >> (4 * (3 - idx)))};
        end else if (idx < POS_REPORT) begin
            ch = {4'h3, code[3:0]};
        end else if (idx < POS_SPACE_A) begin
            ch = {4'h3, 4'(code >> (CODE_REPORT + 4 * (POS_SPACE_A - 1 - idx)))};
        end else if (idx >= POS_FIRST && idx < POS_SPACE_B) begin
            ofs = idx - POS_FIRST;
            ch  = {4'h3, 4'(first >> (4 * (5 - ofs)))};
        end else if (idx >= POS_SECOND && idx < POS_END) begin
            ofs = idx - POS_SECOND;
            ch  = {4'h3, 4'(second >> (4 * (5 - ofs)))};
        end else if (idx == POS_END) begin
            ch = ASCII_CR;
        end
        if (((idx >= POS_FIRST && idx < POS_SPACE_B) || (idx >= POS_SECOND && idx < POS_END))
            && ofs == TD_LAST_OFS) begin
            ch = ASCII_ZERO;
        end
        return ch;
    endfunction

    // ********
    // Next state
    // ********
    always_comb begin
        logic [11:0] eff_int;
        logic        sec_tick;
        logic        trig;
        logic        voice_end;
        logic        start;
        logic        abort;
        eff_int    = 12'h000;
        sec_tick   = 1'b0;
        trig       = 1'b0;
        voice_end  = 1'b0;
        start      = 1'b0;
        abort      = 1'b0;
        next_q     = q;
        fifo_push  = 1'b0;
        fifo_wdata = 8'h00;
        fifo_pop   = 1'b0;
        fifo_flush = 1'b0;

        // Pins cross into the clock domain through two flip-flops
        next_q.inh_meta = i_td_inhibit;
        next_q.inh = q.inh_meta;
        next_q.mic_meta = i_mic_key;
        next_q.mic = q.mic_meta;
        next_q.mic_prev = q.mic;
        next_q.sw_meta = i_transmit_switch;
        next_q.sw = q.sw_meta;
        next_q.sw_prev = q.sw;
        next_q.first_meta  = i_first_time_difference;
        next_q.first_sync  = q.first_meta;
        next_q.second_meta = i_second_time_difference;
        next_q.second_sync = q.second_meta;

        // whatever is displayed is taken as is
        if (!q.inh) begin
            next_q.first_live  = q.first_sync;
            next_q.second_live = q.second_sync;
        end

        // Register writes
        if (i_wr) begin
            if (i_addr == OFS_CTRL) begin
                next_q.ctrl = i_wdata & 16'h0007;
            end else if (i_addr == OFS_INTERVAL) begin
                next_q.interval = i_wdata & 16'h0fff;
            end else if (i_addr == OFS_VESSEL) begin
                next_q.vessel = i_wdata;
            end else if (i_addr == OFS_CODE) begin
                next_q.code = i_wdata & 16'h0fff;
            end
        end

        // Register reads, answered the following cycle
        next_q.rdata = 16'h0000;
        if (i_rd) begin
            if (i_addr == OFS_CTRL) begin
                next_q.rdata = q.ctrl;
            end else if (i_addr == OFS_INTERVAL) begin
                next_q.rdata = q.interval;
            end else if (i_addr == OFS_VESSEL) begin
                next_q.rdata = q.vessel;
            end else if (i_addr == OFS_CODE) begin
                next_q.rdata = q.code;
            end else if (i_addr == OFS_STATUS) begin
                next_q.rdata[STAT_BUSY] = (q.state == ST_SEND);
                next_q.rdata[STAT_KEY] = q.key;
                next_q.rdata[STAT_PENDING] = q.pending;
                next_q.rdata[STAT_VOICE] = q.mic;
                next_q.rdata[STAT_COUNT +: 8] = q.msg_count;
            end
        end

        // ********
        // Interval timer
        // ********
        // setting held within two seconds and 59:59
        eff_int = q.interval[11:0];
        if (eff_int < MIN_INT) begin
            eff_int = MIN_INT;
        end else if (eff_int > MAX_INT) begin
            eff_int = MAX_INT;
        end
        sec_tick = (q.sec_div == SEC_LAST);
        next_q.sec_div = sec_tick ? 27'h0000000 : q.sec_div + 27'h0000001;
        if (sec_tick) begin
            next_q.sec_cnt = q.sec_cnt + 12'h001;
        end

        // timer in auto, switch press in manual
        // period is setting plus inherent delay
        if (q.ctrl[CTRL_AUTO]) begin
            trig = sec_tick && (q.sec_cnt + 12'h001 == eff_int + DELAY_ADD);
        end else begin
            trig = q.sw && !q.sw_prev;
        end
        // only mic-tied mode raises a send request on voice end
        voice_end = q.ctrl[CTRL_MICTIED] && q.mic_prev && !q.mic;
        trig      = trig || voice_end;

        // ********
        // Message control
        // ********
        case (q.state)
            ST_IDLE: begin
                // no start while voice is keyed
                start = q.pending && !q.mic && q.ctrl[CTRL_ENABLE];
                if (start) begin
                    // frozen copy for the whole message
                    next_q.first_snap  = q.first_live;
                    next_q.second_snap = q.second_live;
                    next_q.char_idx    = 5'h00;
                    next_q.key         = 1'b1;
                    next_q.state       = ST_SEND;
                    next_q.sec_cnt     = 12'h000;
                    next_q.sec_div     = 27'h0000000;
                end
            end
            ST_SEND: begin
                // voice drops data, resent after voice
                abort = q.mic;
                if (abort) begin
                    fifo_flush      = 1'b1;
                    next_q.shifting = 1'b0;
                    next_q.tx       = 1'b1;
                    next_q.key      = 1'b0;
                    next_q.state    = ST_IDLE;
                end else begin
                    if (q.char_idx < MSG_END) begin
                        fifo_push  = 1'b1;
                        fifo_wdata = ptf_char(q.char_idx, q.vessel, q.code,
                            q.first_snap, q.second_snap);
                        if (fifo_ready) begin
                            next_q.char_idx = q.char_idx + 5'h01;
                        end
                    end else if (!fifo_valid && !q.shifting) begin
                        // key drops after last stop bit
                        next_q.key       = 1'b0;
                        next_q.state     = ST_IDLE;
                        next_q.msg_count = q.msg_count + 8'h01;
                    end
                end
            end
            default: begin
                next_q.state = ST_IDLE;
            end
        endcase

        // Set wins over the clear made by a start
        next_q.pending = (q.pending && !start) || trig || abort;

        // ********
        // Serial shifter
        // ********
        if (q.state == ST_SEND && !abort) begin
            if (!q.shifting) begin
                if (fifo_valid) begin
                    fifo_pop        = 1'b1;
                    // start bit low, stop bit high
                    next_q.shift    = {1'b1, fifo_rdata, 1'b0};
                    next_q.shifting = 1'b1;
                    next_q.bit_cnt  = 4'h0;
                    next_q.bit_div  = 19'h00000;
                    next_q.tx       = 1'b0;
                end
            end else if (q.bit_div == BIT_LAST) begin
                next_q.bit_div = 19'h00000;
                if (q.bit_cnt == BIT_END) begin
                    next_q.shifting = 1'b0;
                    next_q.tx       = 1'b1;
                end else begin
                    next_q.shift   = {1'b1, q.shift[9:1]};
                    next_q.bit_cnt = q.bit_cnt + 4'h1;
                    next_q.tx      = q.shift[1];
                end
            end else begin
                next_q.bit_div = q.bit_div + 19'h00001;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.ctrl <= CTRL_RST;
            q.interval <= INTERVAL_RST;
            q.vessel <= VESSEL_RST;
            q.code <= CODE_RST;
            q.tx <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Small buffer lets characters be formed ahead of the slow shifter
    ptf_fifo #(
        .WIDTH (CHAR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk,
        .i_reset_n,
        .i_flush    (fifo_flush),
        .i_wr_valid (fifo_push),
        .i_wr_data  (fifo_wdata),
        .o_wr_ready (fifo_ready),
        .o_rd_valid (fifo_valid),
        .o_rd_data  (fifo_rdata),
        .i_rd_ready (fifo_pop)
    );

    assign o_rdata     = q.rdata;
    assign o_tx_serial = q.tx;
    assign o_tx_key    = q.key;

endmodule
